// file: rtl/dvr_defines.svh
// constants for the dac digital volume register bank
// assumes inclusion by bare name from design files
`ifndef DVR_DEFINES_SVH
`define DVR_DEFINES_SVH
`define DVR_ADDR_W 7
`define DVR_DATA_W 9
`define DVR_CODE_W 8
`define DVR_NUM_CH 6
`define DVR_OFF_L1 7'h00
`define DVR_OFF_R1 7'h01
`define DVR_OFF_L2 7'h04
`define DVR_OFF_R2 7'h05
`define DVR_OFF_L3 7'h06
`define DVR_OFF_R3 7'h07
`define DVR_OFF_MASTER 7'h08
`define DVR_OFF_SWRESET 7'h1F
`define DVR_OFF_STATUS 7'h10
`define DVR_UPDATE_BIT 8
`define DVR_CODE_RESET 8'hFF
`define DVR_CODE_MUTE 8'h00
`define DVR_STEP_TENTHS_DB 5
`define DVR_FLOOR_TENTHS_DB 1270
`endif

// file: rtl/dvr_pkg.sv
// types for the dac digital volume register bank
// assumes dvr_defines.svh is on the include path
`include "dvr_defines.svh"
package dvr_pkg;
  typedef logic [`DVR_CODE_W-1:0] dvr_code_t;
  typedef struct packed {
    logic write;
    logic read;
    logic [`DVR_ADDR_W-1:0] addr;
    logic [`DVR_DATA_W-1:0] wdata;
  } dvr_bus_t;
  typedef struct packed {
    logic mute;
    logic [10:0] atten_tenths_db;
  } dvr_level_t;
  typedef enum logic [0:0] {
    DVR_RUN,
    DVR_HELD
  } dvr_mode_t;
endpackage

// file: rtl/dvr_code_bank.sv
// six-entry code store with registered read port
// assumes same clock and enable as the register bank
`timescale 1ns/100ps
`default_nettype none
`include "dvr_defines.svh"
module dvr_code_bank #(
  parameter int unsigned entries = `DVR_NUM_CH
) (
  input wire logic clock, // system clock
  input wire logic clock_enable, // freeze when low
  input wire logic reset, // sync reset, high
  input wire logic [entries-1:0] write_enable, // per-entry write
  input wire logic [entries-1:0][`DVR_CODE_W-1:0] write_data, // per-entry data
  input wire logic [$clog2(entries)-1:0] read_index, // read select
  output logic [`DVR_CODE_W-1:0] read_data, // registered read
  output logic [entries-1:0][`DVR_CODE_W-1:0] contents // all entries
);
  typedef struct packed {
    logic [entries-1:0][`DVR_CODE_W-1:0] mem;
    logic [`DVR_CODE_W-1:0] rd;
  } dvr_bank_state_t;
  dvr_bank_state_t state;
  dvr_bank_state_t next_state;
  always_comb begin
    next_state = state;
    for (int i = 0; i < entries; i++) begin
      if (write_enable[i]) begin
        next_state.mem[i] = write_data[i];
      end
    end
    next_state.rd = state.mem[read_index];
    if (reset) begin
      for (int i = 0; i < entries; i++) begin
        next_state.mem[i] = `DVR_CODE_RESET;
      end
      next_state.rd = `DVR_CODE_RESET;
    end
  end
  always_ff @(posedge clock) begin
    if (reset || clock_enable) begin
      state <= next_state;
    end
  end
  assign read_data = state.rd;
  assign contents = state.mem;
endmodule
`default_nettype wire

// file: rtl/dvr_volume_regs.sv
// dac digital volume register bank for six channels
// assumes a host on the same clock using the plain strobe port
// What this block does
// - six channel registers, eight-bit half-decibel codes
// - channel codes default to all ones
// - pair addresses 04/05 and 06/07
// - update clear parks code in latch
// - update set stores, commits all channels
// - master register at 08 sets all
// - master update bit behaves the same
// - code 00 mutes, 01 is -127 dB
// - write to 1F resets all registers
// - held in reset until next write
`timescale 1ns/100ps
`default_nettype none
`include "dvr_defines.svh"
module dvr_volume_regs (
  input wire logic clock, // 125 MHz system clock
  input wire logic clock_enable, // freezes all state when low
  input wire logic reset, // sync reset, high
  input wire dvr_pkg::dvr_bus_t bus, // host strobes, address, data
  output logic [`DVR_DATA_W-1:0] read_data, // read answer, cycle after strobe
  output dvr_pkg::dvr_code_t left_output_pair1, // applied code
  output dvr_pkg::dvr_code_t right_output_pair1, // applied code
  output dvr_pkg::dvr_code_t left_output_pair2, // applied code
  output dvr_pkg::dvr_code_t right_output_pair2, // applied code
  output dvr_pkg::dvr_code_t left_output_pair3, // applied code
  output dvr_pkg::dvr_code_t right_output_pair3, // applied code
  output logic [`DVR_NUM_CH-1:0] channel_mute, // applied code is mute
  output logic soft_reset_held // device held in reset
);
  import dvr_pkg::*;

  localparam int unsigned nch = `DVR_NUM_CH;

  ////////////////////////////////////////////////////////////////////////////
  // state
  typedef struct packed {
    logic [nch-1:0][`DVR_CODE_W-1:0] applied;
    logic [nch-1:0] mute;
    dvr_mode_t mode;
    logic [`DVR_DATA_W-1:0] rdata;
  } dvr_state_t;

  dvr_state_t state;
  dvr_state_t next_state;

  ////////////////////////////////////////////////////////////////////////////
  // decode
  logic [nch-1:0] hit;
  logic hit_master;
  logic hit_swreset;
  logic hit_status;
  logic update;
  logic [nch-1:0] latch_we;
  logic [nch-1:0][`DVR_CODE_W-1:0] latch_wd;
  logic [nch-1:0][`DVR_CODE_W-1:0] pending;
  logic [$clog2(nch)-1:0] rd_index;
  logic bank_reset;
  logic [`DVR_CODE_W-1:0] wcode;
  logic [nch-1:0][`DVR_ADDR_W-1:0] ch_off;

  assign ch_off[0] = `DVR_OFF_L1;
  assign ch_off[1] = `DVR_OFF_R1;
  assign ch_off[2] = `DVR_OFF_L2;
  assign ch_off[3] = `DVR_OFF_R2;
  assign ch_off[4] = `DVR_OFF_L3;
  assign ch_off[5] = `DVR_OFF_R3;

  assign hit_master = bus.addr == `DVR_OFF_MASTER;
  assign hit_swreset = bus.addr == `DVR_OFF_SWRESET;
  assign hit_status = bus.addr == `DVR_OFF_STATUS;
  // update bit only steers the commit, never stored
  assign update = bus.wdata[`DVR_UPDATE_BIT];
  assign wcode = bus.wdata[`DVR_CODE_W-1:0];

  genvar g;
  generate
    for (g = 0; g < nch; g++) begin : g_ch
      assign hit[g] = bus.addr == ch_off[g];
      // master write lands in every latch
      assign latch_we[g] = bus.write && !hit_swreset
                           && (hit[g] || hit_master);
      assign latch_wd[g] = wcode;
    end
  endgenerate

  // writes during the hold only release it
  // a frozen cycle must not clear the latches
  assign bank_reset = reset || (clock_enable && bus.write && hit_swreset) ||
                      (state.mode == DVR_HELD);

  always_comb begin
    rd_index = '0;
    for (int i = 0; i < nch; i++) begin
      if (hit[i]) begin
        rd_index = i[$clog2(nch)-1:0];
      end
    end
  end

  dvr_code_bank #(
    .entries(nch)
  ) i_dvr_code_bank (
    .clock(clock),
    .clock_enable(clock_enable),
    .reset(bank_reset),
    .write_enable(latch_we),
    .write_data(latch_wd),
    .read_index(rd_index),
    .read_data(),
    .contents(pending)
  );

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    next_state = state;
    next_state.rdata = '0;
    if (bus.read) begin
      if (|hit) begin
        // pending code, so read_data leaves a single flop
        next_state.rdata = {1'b0, pending[rd_index]};
      end else if (hit_master) begin
        next_state.rdata = {1'b0, state.applied[0]};
      end else if (hit_status) begin
        next_state.rdata = {{(`DVR_DATA_W-1){1'b0}}, state.mode == DVR_HELD};
      end
    end
    unique case (state.mode)
      DVR_RUN: begin
        if (bus.write && hit_swreset) begin
          next_state.mode = DVR_HELD;
          for (int i = 0; i < nch; i++) begin
            next_state.applied[i] = `DVR_CODE_RESET;
          end
        end else if (bus.write && update && ((|hit) || hit_master)) begin
          // commit all channels at once, taking this write's code too
          for (int i = 0; i < nch; i++) begin
            next_state.applied[i] = latch_we[i] ? wcode : pending[i];
          end
        end
      end
      DVR_HELD: begin
        // any completed write ends the hold; its content is discarded
        if (bus.write) begin
          next_state.mode = DVR_RUN;
        end
      end
    endcase
    for (int i = 0; i < nch; i++) begin
      next_state.mute[i] = next_state.applied[i] == `DVR_CODE_MUTE;
    end
    if (reset) begin
      for (int i = 0; i < nch; i++) begin
        next_state.applied[i] = `DVR_CODE_RESET;
        next_state.mute[i] = 1'b0;
      end
      next_state.mode = DVR_RUN;
      next_state.rdata = '0;
    end
  end

  always_ff @(posedge clock) begin
    if (reset || clock_enable) begin
      state <= next_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign read_data = state.rdata;
  assign left_output_pair1 = state.applied[0];
  assign right_output_pair1 = state.applied[1];
  assign left_output_pair2 = state.applied[2];
  assign right_output_pair2 = state.applied[3];
  assign left_output_pair3 = state.applied[4];
  assign right_output_pair3 = state.applied[5];
  assign channel_mute = state.mute;
  assign soft_reset_held = state.mode == DVR_HELD;
endmodule
`default_nettype wire

// file: sim/dvr_host_model.sv
// host model issuing strobe cycles to the volume bank
// assumes one clock shared with the bank
`timescale 1ns/100ps
`default_nettype none
module dvr_host_model (
  input wire logic clock, // system clock
  output var dvr_pkg::dvr_bus_t bus // host strobes
);
  import dvr_pkg::*;
  initial bus = '0;
  // one-cycle strobe, then idle; w high writes, low reads
  task automatic put(input logic w, input logic [6:0] a, input logic [8:0] d);
    @(posedge clock);
    bus <= '{w, !w, a, d};
    @(posedge clock);
    bus <= '{1'b0, 1'b0, ~a, ~d}; // released lines show no stale value
    #1;
  endtask
endmodule
`default_nettype wire

// file: sim/dvr_volume_regs_properties.sv
// port assertions for the volume register bank
// assumes bind into dvr_volume_regs
`timescale 1ns/100ps
`default_nettype none
module dvr_volume_regs_properties (
  input wire logic clock, // clock
  input wire logic clock_enable, // enable
  input wire logic reset, // reset
  input wire dvr_pkg::dvr_bus_t bus, // host bus
  input wire logic [8:0] read_data, // read answer
  input wire dvr_pkg::dvr_code_t left_output_pair1, // applied
  input wire dvr_pkg::dvr_code_t right_output_pair1, // applied
  input wire dvr_pkg::dvr_code_t left_output_pair2, // applied
  input wire dvr_pkg::dvr_code_t right_output_pair2, // applied
  input wire dvr_pkg::dvr_code_t left_output_pair3, // applied
  input wire dvr_pkg::dvr_code_t right_output_pair3, // applied
  input wire logic [5:0] channel_mute, // mute flags
  input wire logic soft_reset_held // hold
);
  import dvr_pkg::*;
  wire logic [47:0] outs = {right_output_pair3, left_output_pair3, right_output_pair2,
    left_output_pair2, right_output_pair1, left_output_pair1};
  wire logic wr = bus.write && clock_enable && !soft_reset_held;
  wire logic [7:0] code = bus.wdata[7:0];
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  a_mute_flag: assert property (channel_mute[0] == (left_output_pair1 == 8'h00)
    && channel_mute[5] == (right_output_pair3 == 8'h00)) else $error("mute flag wrong");
  a_park_hold: assert property (wr && !bus.wdata[8] && bus.addr != 7'h1F
    |=> $stable(outs)) else $error("parked write moved output");
  a_swreset_enter: assert property (wr && bus.addr == 7'h1F
    |=> soft_reset_held && outs == {6{8'hFF}}) else $error("soft reset missed");
  a_hold_release: assert property (soft_reset_held && bus.write && clock_enable
    |=> !soft_reset_held) else $error("hold not released");
  a_held_default: assert property (soft_reset_held |-> outs == {6{8'hFF}})
    else $error("held with non-default code");
  a_master_commit: assert property (wr && bus.addr == 7'h08 && bus.wdata[8]
    |=> outs == {6{$past(code)}}) else $error("master commit wrong");
  a_channel_commit: assert property (wr && bus.addr == 7'h01 && bus.wdata[8]
    |=> right_output_pair1 == $past(code)) else $error("channel commit wrong");
  a_update_unkept: assert property (bus.read && clock_enable && !soft_reset_held
    |=> !read_data[8]) else $error("update bit retained");
  a_freeze_hold: assert property (!clock_enable |=> $stable(outs)
    && $stable(soft_reset_held)) else $error("state moved while frozen");
  c_commit: cover property (wr && bus.wdata[8]);
  c_release: cover property (soft_reset_held && bus.write);
  c_master: cover property (wr && bus.addr == 7'h08);
endmodule
bind dvr_volume_regs dvr_volume_regs_properties i_dvr_volume_regs_properties (.*);
`default_nettype wire

// file: sim/dvr_volume_regs_tb_top.sv
// self-checking bench for the volume register bank
// assumes the host model and checker files compiled first
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin err_count++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, a, e); end end
module dvr_volume_regs_tb_top;
  import dvr_pkg::*;
  logic clock = 0;
  logic reset = 1;
  logic clock_enable = 1;
  dvr_bus_t bus;
  logic [8:0] read_data;
  dvr_code_t [5:0] o;
  logic [5:0] channel_mute;
  logic soft_reset_held;
  int err_count = 0;
  int checked = 0;
  int cycles = 0;
  logic [6:0] ch [6] = '{7'h00, 7'h01, 7'h04, 7'h05, 7'h06, 7'h07};
  always #4 clock = ~clock;
  dvr_host_model i_dvr_host_model (.clock(clock), .bus(bus));
  dvr_volume_regs i_dvr_volume_regs (.clock(clock), .clock_enable(clock_enable), .reset(reset),
    .bus(bus), .read_data(read_data), .left_output_pair1(o[0]), .right_output_pair1(o[1]),
    .left_output_pair2(o[2]), .right_output_pair2(o[3]), .left_output_pair3(o[4]),
    .right_output_pair3(o[5]), .channel_mute(channel_mute), .soft_reset_held(soft_reset_held));
  task automatic finish_test();
    if (err_count == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic wr(input logic [6:0] a, input logic [8:0] d);
    i_dvr_host_model.put(1'b1, a, d);
  endtask
  task automatic rd(input logic [6:0] a, input logic [8:0] e);
    i_dvr_host_model.put(1'b0, a, 9'h000);
    `CHK(read_data, e)
  endtask
  always @(posedge clock) begin
    cycles++;
    if (cycles > 3000) begin
      err_count++;
      finish_test();
    end
  end
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(posedge clock);
    reset <= 1'b0;
    foreach (ch[i]) rd(ch[i], 9'h0FF);
    `CHK(o, {6{8'hFF}})
    `CHK(channel_mute, 6'h00)
    wr(7'h04, 9'h040);
    `CHK(o, {6{8'hFF}})
    rd(7'h04, 9'h040);
    wr(7'h01, 9'h120);
    `CHK(o, 48'hFFFFFF4020FF)
    rd(7'h01, 9'h020);
    wr(7'h00, 9'h100);
    `CHK(channel_mute, 6'h01)
    wr(7'h08, 9'h033);
    `CHK(o, 48'hFFFFFF402000)
    wr(7'h07, 9'h1AA);
    `CHK(o, 48'hAA3333333333)
    wr(7'h08, 9'h150);
    `CHK(o, {6{8'h50}})
    rd(7'h08, 9'h050);
    // frozen cycle: a committing write must not land
    @(posedge clock);
    clock_enable <= 1'b0;
    wr(7'h01, 9'h1AB);
    `CHK(o, {6{8'h50}})
    @(posedge clock);
    clock_enable <= 1'b1;
    rd(7'h01, 9'h050);
    rd(7'h02, 9'h000);
    wr(7'h1F, 9'h000);
    `CHK(soft_reset_held, 1'b1)
    `CHK(o, {6{8'hFF}})
    rd(7'h10, 9'h001);
    wr(7'h04, 9'h111);
    `CHK(soft_reset_held, 1'b0)
    rd(7'h10, 9'h000);
    rd(7'h04, 9'h0FF);
    finish_test();
  end
endmodule
`default_nettype wire
